// [rtl/wsc_pkg.sv]
package wsc_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int N_WAKE = 9;

  // register map
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 14'h0003;
  localparam logic [ADDR_W-1:0] IRQCTL_ADDR = 14'h000B;
  localparam logic [ADDR_W-1:0] OPTION_ADDR = 14'h0081;
  localparam logic [ADDR_W-1:0] PIE_LO_ADDR = 14'h008C;
  localparam logic [ADDR_W-1:0] PIE_HI_ADDR = 14'h008D;
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 14'h2007;

  // option_control fields
  localparam int OPT_PS_LSB = 0;
  localparam int OPT_PS_W   = 3;
  localparam int OPT_PSA    = 3;
  localparam int OPT_EDGE   = 6;

  // irq_control_reg fields
  localparam int IRQ_GIE  = 7;
  localparam int IRQ_PEIE = 6;
  localparam int IRQ_T0IE = 5;
  localparam int IRQ_INTE = 4;
  localparam int IRQ_RBIE = 3;
  localparam int IRQ_T0IF = 2;
  localparam int IRQ_INTF = 1;
  localparam int IRQ_RBIF = 0;

  // status fields
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;

  // device_config_word fields
  localparam int CFG_WATCHDOG_ENABLE_FUSE = 2;

  // reset values
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
  localparam logic [DATA_W-1:0] IRQCTL_RST = 8'h00;
  localparam logic [N_WAKE-1:0] PIE_RST    = 9'h000;
  localparam logic [DATA_W-1:0] CONFIG_RST = 8'hFF;

  localparam logic [12:0] VECTOR_ADDR = 13'h0004;

  typedef enum logic [1:0] {
    WSC_RUN   = 2'b01,
    WSC_SLEEP = 2'b10
  } wsc_state_e;
endpackage

// [rtl/wsc_watchdog_sleep.sv]
// Operation
// - vectoring pushes only the return PC
// - watchdog counts its own RC oscillator
// - run-mode time-out causes watchdog device reset
// - sleep time-out wakes and resumes execution
// - every time-out clears the time-out flag
// - cleared enable fuse disables watchdog entirely
// - shared prescaler, option selects watchdog or timer
// - clear/sleep instruction clears watchdog and postscaler
// - clearing keeps the prescaler assignment
// - sleep clears watchdog, PD low, TO high, osc off
// - pins hold their drive state in sleep
// - wake on master clear, time-out or interrupt
// - master clear resets, others continue execution
// - PD set at power-up, cleared on sleep
// - only clockless peripherals can wake the device
// - clocked peripherals raise nothing during sleep
// - sleep instruction prefetches the next address
// - enabled source wakes regardless of global enable
// - after wake, run next instruction then vector
// - global enable bit 7 gates all vectoring
// - pending enabled interrupt makes sleep a no-op
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module wsc_watchdog_sleep #(
  parameter int WDT_BASE_TICKS = 1024
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  // register port
  input  wire logic [wsc_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [wsc_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [wsc_pkg::DATA_W-1:0]  o_rdata,
  // configuration strap
  input  wire logic [wsc_pkg::DATA_W-1:0]  i_config_word,
  // pins
  input  wire logic                        i_wdt_osc,
  input  wire logic                        i_master_clear_pin_n,
  input  wire logic                        i_ext_irq,
  // instruction sequencer
  input  wire logic                        i_clear_watchdog_instr,
  input  wire logic                        i_sleep,
  input  wire logic                        i_instr_done,
  output logic                             o_prefetch_next,
  output logic                             o_vector,
  output logic                             o_wake,
  output logic                             o_dev_reset,
  output logic                             o_wdt_reset,
  // power control
  output logic                             o_sleeping,
  output logic                             o_main_osc_en,
  output logic                             o_io_hold,
  // event sources
  input  wire logic                        i_port_change,
  input  wire logic                        i_t0_tick,
  input  wire logic                        i_t0_overflow,
  input  wire logic [wsc_pkg::N_WAKE-1:0]  i_periph_flag,
  input  wire logic                        i_clocked_irq,
  output logic                             o_t0_inc
);
  import wsc_pkg::*;

  // the real period is only known as an electrical spread, so the terminal
  // count is a parameter; simulation runs with a short one to save cycles
  localparam int CNT_W = $clog2(WDT_BASE_TICKS);
  localparam logic [CNT_W-1:0] BASE_LAST = CNT_W'(WDT_BASE_TICKS - 1);

  // 2^(ps+extra) - 1: watchdog ratio 1:1..1:128, timer ratio 1:2..1:256
  function automatic logic [7:0] ps_limit(input logic [OPT_PS_W-1:0] ps, input logic extra);
    logic [8:0] one_hot;
    one_hot  = 9'h001 << ({1'b0, ps} + {3'b000, extra});
    ps_limit = 8'(one_hot - 9'h001);
  endfunction

  wsc_state_e              state;
  logic [DATA_W-1:0]       option;
  logic [DATA_W-1:0]       irqctl;
  logic [N_WAKE-1:0]       pie;
  logic [DATA_W-1:0]       cfg;
  logic                    cfg_loaded;
  logic                    to_flag;
  logic                    pd_flag;
  logic [CNT_W-1:0]        wdt_cnt;
  logic [7:0]              psc;
  logic [2:0]              osc_s;
  logic [2:0]              master_clear_pin_s;
  logic [2:0]              ext_s;
  logic                    osc_lvl;
  logic                    osc_lvl_d;
  logic                    master_clear_pin_lvl;
  logic                    master_clear_pin_lvl_d;
  logic                    ext_lvl;
  logic                    ext_lvl_d;

  logic                    asleep;
  logic                    osc_tick;
  logic                    master_clear_pin_event;
  logic                    ext_edge;
  logic                    prescaler_assign_sel;
  logic [OPT_PS_W-1:0]     ps;
  logic                    wdt_en;
  logic                    base_to;
  logic                    wdt_timeout;
  logic                    periph_pend;
  logic                    pending_int;
  logic                    sleep_enter;
  logic                    run_wdt_reset;
  logic                    soft_rst;
  logic                    wdt_clear;
  logic                    vector_now;
  logic                    t0_tick_ok;
  logic                    t0_hit;
  logic [DATA_W-1:0]       next_irqctl;
  logic [DATA_W-1:0]       status_rd;

  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_s      <= 3'h0;
      master_clear_pin_s     <= 3'h7;
      ext_s      <= 3'h0;
      osc_lvl    <= 1'b0;
      master_clear_pin_lvl   <= 1'b1;
      ext_lvl    <= 1'b0;
      osc_lvl_d  <= 1'b0;
      master_clear_pin_lvl_d <= 1'b1;
      ext_lvl_d  <= 1'b0;
    end else begin
      osc_s      <= {osc_s[1:0], i_wdt_osc};
      master_clear_pin_s     <= {master_clear_pin_s[1:0], i_master_clear_pin_n};
      ext_s      <= {ext_s[1:0], i_ext_irq};
      if (osc_s[2] == osc_s[1]) begin
        osc_lvl <= osc_s[2];
      end
      if (master_clear_pin_s[2] == master_clear_pin_s[1]) begin
        master_clear_pin_lvl <= master_clear_pin_s[2];
      end
      if (ext_s[2] == ext_s[1]) begin
        ext_lvl <= ext_s[2];
      end
      osc_lvl_d  <= osc_lvl;
      master_clear_pin_lvl_d <= master_clear_pin_lvl;
      ext_lvl_d  <= ext_lvl;
    end
  end

  // the RC oscillator is sampled, never used as a clock, so the
  // always-on i_clk must keep running while the core clock is stopped
  assign osc_tick   = osc_lvl & ~osc_lvl_d;
  assign master_clear_pin_event = ~master_clear_pin_lvl & master_clear_pin_lvl_d;
  assign ext_edge   = option[OPT_EDGE] ? (ext_lvl & ~ext_lvl_d) : (~ext_lvl & ext_lvl_d);


  assign asleep = (state == WSC_SLEEP);
  assign prescaler_assign_sel    = option[OPT_PSA];
  assign ps     = option[OPT_PS_LSB +: OPT_PS_W];
  assign wdt_en = cfg[CFG_WATCHDOG_ENABLE_FUSE];

  // clocked peripherals are silenced in sleep; listed sources are clockless
  assign periph_pend = irqctl[IRQ_PEIE] & ((|(pie & i_periph_flag))
                                           | (i_clocked_irq & ~asleep));

  // independent of the global enable, so it serves wake-up too
  assign pending_int = (irqctl[IRQ_T0IE] & irqctl[IRQ_T0IF])
                     | (irqctl[IRQ_INTE] & irqctl[IRQ_INTF])
                     | (irqctl[IRQ_RBIE] & irqctl[IRQ_RBIF])
                     | periph_pend;

  assign base_to     = osc_tick & (wdt_cnt == BASE_LAST);
  assign wdt_timeout = wdt_en & base_to & (~prescaler_assign_sel | (psc == ps_limit(ps, 1'b0)));

  assign run_wdt_reset = wdt_timeout & ~asleep;
  assign soft_rst      = run_wdt_reset | master_clear_pin_event;
  assign sleep_enter   = i_sleep & ~asleep & ~pending_int & ~soft_rst;
  assign wdt_clear     = i_clear_watchdog_instr | sleep_enter | soft_rst;

  assign vector_now = ~asleep & i_instr_done & irqctl[IRQ_GIE] & pending_int & ~soft_rst;

  // the timer has no clock in sleep, so its ticks are ignored there

  assign t0_tick_ok = i_t0_tick & ~prescaler_assign_sel & ~asleep;
  assign t0_hit     = t0_tick_ok & (psc == ps_limit(ps, 1'b1));

  // configuration fuse is caught once, after reset release
  // a later change of the strap has no effect until the next power-on reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg        <= CONFIG_RST;
      cfg_loaded <= 1'b0;
    end else if (!cfg_loaded) begin
      cfg        <= i_config_word;
      cfg_loaded <= 1'b1;
    end
  end

  // base watchdog counter
  // a soft reset clears it too, so a watchdog reset never repeats at once
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wdt_cnt <= '0;
    end else if (wdt_clear) begin
      wdt_cnt <= '0;
    end else if (osc_tick) begin
      wdt_cnt <= base_to ? '0 : CNT_W'(wdt_cnt + 1'b1);
    end
  end

  // shared prescaler: postscaler on time-outs or prescaler on timer ticks
  // limitation: a clear while the prescaler serves the timer leaves its count,
  // so the timer's phase survives clear-watchdog and sleep
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      psc <= 8'h00;
    end else if (wdt_clear && prescaler_assign_sel) begin
      psc <= 8'h00;
    end else if (prescaler_assign_sel && base_to) begin
      psc <= wdt_timeout ? 8'h00 : 8'(psc + 1'b1);
    end else if (t0_tick_ok) begin
      psc <= t0_hit ? 8'h00 : 8'(psc + 1'b1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_t0_inc <= 1'b0;
    end else begin
      o_t0_inc <= t0_hit;
    end
  end

  // sleep state machine
  // every wake source leaves sleep here; only master clear also resets,
  // the rest resume with the instruction that was prefetched
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= WSC_RUN;
    end else begin
      case (state)
        WSC_RUN: begin
          if (sleep_enter) begin
            state <= WSC_SLEEP;
          end
        end
        WSC_SLEEP: begin
          if (master_clear_pin_event || wdt_timeout || pending_int) begin
            state <= WSC_RUN;
          end
        end
        default: begin
          state <= WSC_RUN;
        end
      endcase
    end
  end

  // decoded from the state register alone so none of these can glitch

  assign o_sleeping    = asleep;
  assign o_main_osc_en = ~asleep;
  assign o_io_hold     = asleep;

  // sequencer pulses
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prefetch_next <= 1'b0;
      o_vector        <= 1'b0;
      o_wake          <= 1'b0;
      o_dev_reset     <= 1'b0;
      o_wdt_reset     <= 1'b0;
    end else begin
      o_prefetch_next <= i_sleep & ~asleep;
      // only the return PC goes on the stack; W, status, page latch are software's
      o_vector        <= vector_now;
      o_wake          <= asleep & ~master_clear_pin_event & (wdt_timeout | pending_int);
      o_dev_reset     <= soft_rst;
      o_wdt_reset     <= run_wdt_reset;
    end
  end

  // status flags: time-out clear beats a same-cycle sleep entry
  // master clear keeps both flags and a watchdog reset clears only TO, which is how software tells the causes apart
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      to_flag <= 1'b1;
      pd_flag <= 1'b1;
    end else begin
      if (wdt_timeout) begin
        to_flag <= 1'b0;
      end else if (sleep_enter) begin
        to_flag <= 1'b1;
      end
      if (sleep_enter) begin
        pd_flag <= 1'b0;
      end
    end
  end

  // irq control: hardware sets win over a software clear in the same cycle
  // so an edge arriving while software clears a flag is never lost
  always_comb begin
    next_irqctl = irqctl;
    if (i_wr && i_addr == IRQCTL_ADDR) begin
      next_irqctl = i_wdata;
    end
    if (vector_now) begin
      next_irqctl[IRQ_GIE] = 1'b0;
    end
    if (ext_edge) begin
      next_irqctl[IRQ_INTF] = 1'b1;
    end
    if (i_port_change) begin
      next_irqctl[IRQ_RBIF] = 1'b1;
    end
    if (i_t0_overflow && !asleep) begin
      next_irqctl[IRQ_T0IF] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || soft_rst) begin
      irqctl <= IRQCTL_RST;
    end else begin
      irqctl <= next_irqctl;
    end
  end

  // option and wake-enable registers; a clear never touches the assignment bit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || soft_rst) begin
      option <= OPTION_RST;
      pie    <= PIE_RST;
    end else if (i_wr) begin
      if (i_addr == OPTION_ADDR) begin
        option <= i_wdata;
      end
      if (i_addr == PIE_LO_ADDR) begin
        pie[DATA_W-1:0] <= i_wdata;
      end
      if (i_addr == PIE_HI_ADDR) begin
        pie[N_WAKE-1] <= i_wdata[0];
      end
    end
  end

  // status reads back only the two power flags; the rest read zero

  always_comb begin
    status_rd        = '0;
    status_rd[ST_TO] = to_flag;
    status_rd[ST_PD] = pd_flag;
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        STATUS_ADDR: o_rdata <= status_rd;
        IRQCTL_ADDR: o_rdata <= irqctl;
        OPTION_ADDR: o_rdata <= option;
        PIE_LO_ADDR: o_rdata <= pie[DATA_W-1:0];
        PIE_HI_ADDR: o_rdata <= {{(DATA_W-1){1'b0}}, pie[N_WAKE-1]};
        CONFIG_ADDR: o_rdata <= cfg;
        default:     o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end
endmodule

// [tb/wsc_checker.sv]
`timescale 1ns/100ps
module wsc_checker (
  // clock and reset
  input wire logic                       i_clk,
  input wire logic                       i_rst_n,
  // watched ports
  input wire logic                       i_sleep,
  input wire logic [wsc_pkg::DATA_W-1:0] i_config_word,
  input wire logic                       o_prefetch_next,
  input wire logic                       o_vector,
  input wire logic                       o_wake,
  input wire logic                       o_dev_reset,
  input wire logic                       o_wdt_reset,
  input wire logic                       o_sleeping,
  input wire logic                       o_main_osc_en,
  input wire logic                       o_io_hold
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_sleep_req;
    i_sleep && !o_sleeping && !o_dev_reset;
  endsequence
  sequence s_left_sleep;
    !o_sleeping && $past(o_sleeping);
  endsequence
  property p_enter;
    s_sleep_req |=> o_prefetch_next || o_dev_reset;
  endproperty

  sleep_prefetch_a: assert property (p_enter)
    else $error("sleep did not prefetch");
  osc_stop_a: assert property (o_sleeping |-> !o_main_osc_en)
    else $error("main oscillator on in sleep");
  pins_hold_a: assert property (o_io_hold == o_sleeping)
    else $error("pin hold differs from sleep");
  sleep_cause_a: assert property ($rose(o_sleeping) |-> $past(i_sleep))
    else $error("sleep without instruction");
  wake_exit_a: assert property (o_wake |-> s_left_sleep)
    else $error("wake pulse outside sleep exit");
  wdt_kind_a: assert property (o_wdt_reset |-> o_dev_reset && !$past(o_sleeping))
    else $error("watchdog reset kind wrong");
  fuse_gate_a: assert property (o_wdt_reset |-> i_config_word[wsc_pkg::CFG_WATCHDOG_ENABLE_FUSE])
    else $error("watchdog reset with fuse cleared");
  vector_run_a: assert property (o_vector |-> !o_sleeping ##1 !o_vector)
    else $error("vector in sleep or too long");
  reset_nowake_a: assert property (o_dev_reset |-> !o_wake ##1 !o_sleeping)
    else $error("reset mixed with wake");
endmodule

bind wsc_watchdog_sleep wsc_checker u_chk (.i_clk, .i_rst_n, .i_sleep, .i_config_word, .o_prefetch_next,
  .o_vector, .o_wake, .o_dev_reset, .o_wdt_reset, .o_sleeping, .o_main_osc_en, .o_io_hold);

// [tb/wsc_core_model.sv]
`timescale 1ns/100ps
module wsc_core_model (
  // clock and control
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_kick_en,
  input  wire logic i_sleeping,
  // sequencer outputs
  output logic      o_clear_watchdog_instr,
  output logic      o_instr_done,
  output logic      o_wdt_osc
);
  logic [3:0] cnt;

  // free running, unrelated in phase to the core clock
  initial o_wdt_osc = 1'b0;
  always #130 o_wdt_osc = ~o_wdt_osc;

  // the core is frozen in sleep, so neither kicks nor retires anything there
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_sleeping) begin
      cnt          <= 4'h0;
      o_clear_watchdog_instr     <= 1'b0;
      o_instr_done <= 1'b0;
    end else begin
      cnt          <= cnt + 4'h1;
      o_clear_watchdog_instr     <= i_kick_en && cnt == 4'hF;
      o_instr_done <= cnt[1:0] == 2'h3;
    end
  end
endmodule

// [tb/wsc_watchdog_sleep_test.sv]
`timescale 1ns/100ps
module wsc_watchdog_sleep_test;
  import wsc_pkg::*;
  logic              i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_sleep = 0, i_master_clear_pin_n = 1;
  logic              i_ext_irq = 0, i_clocked_irq = 0, kick = 1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0, i_config_word = 8'hFF, o_rdata, d;
  logic [N_WAKE-1:0] i_periph_flag = '0, m;
  logic              i_wdt_osc, i_clear_watchdog_instr, i_instr_done, o_prefetch_next, o_vector, o_wake;
  logic              o_dev_reset, o_wdt_reset, o_sleeping, o_main_osc_en, o_io_hold;
  int                n_fail = 0, compares = 0, nwk = 0, nrs = 0, nvc = 0, b, k;

  always #10 i_clk = ~i_clk;

  wsc_watchdog_sleep #(.WDT_BASE_TICKS(4)) u_dut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_config_word, .i_wdt_osc, .i_master_clear_pin_n, .i_ext_irq, .i_clear_watchdog_instr, .i_sleep, .i_instr_done, .o_prefetch_next,
    .o_vector, .o_wake, .o_dev_reset, .o_wdt_reset, .o_sleeping, .o_main_osc_en, .o_io_hold,
    .i_port_change(1'b0), .i_t0_tick(1'b0), .i_t0_overflow(1'b0), .i_periph_flag, .i_clocked_irq, .o_t0_inc());

  wsc_core_model u_core (.i_clk, .i_rst_n, .i_kick_en(kick), .i_sleeping(o_sleeping), .o_clear_watchdog_instr(i_clear_watchdog_instr),
    .o_instr_done(i_instr_done), .o_wdt_osc(i_wdt_osc));

  always @(posedge i_clk) begin
    nwk <= nwk + o_wake;
    nrs <= nrs + o_dev_reset;
    nvc <= nvc + o_vector;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
    @(posedge i_clk);
  endtask
  task automatic waitev(ref int c, input int n);
    int s;
    s = c;
    repeat (n) if (c == s) @(posedge i_clk);
  endtask
  task automatic dosleep;
    i_sleep <= 1'b1;
    @(posedge i_clk);
    i_sleep <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic summarize;
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    summarize();
  end

  initial begin
    void'($urandom(63573));
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    rdc(STATUS_ADDR, 8'h18);
    rdc(IRQCTL_ADDR, IRQCTL_RST);
    wr(CONFIG_ADDR, 8'h00);
    wr(14'h0055, 8'hA5);
    rdc(CONFIG_ADDR, 8'hFF);
    rdc(14'h0055, 8'h00);
    rdc(OPTION_ADDR, OPTION_RST);
    d = 8'($urandom);
    wr(OPTION_ADDR, d);
    repeat (40) @(posedge i_clk);
    rdc(OPTION_ADDR, d);
    // watchdog wake with a 1:1 postscaler
    wr(OPTION_ADDR, 8'h48);
    dosleep();
    #1 chk(o_sleeping, 1'b1);
    chk(o_main_osc_en, 1'b0);
    chk(o_io_hold, 1'b1);
    @(posedge i_clk);
    rdc(STATUS_ADDR, 8'h10);
    b = nwk;
    k = nrs;
    waitev(nwk, 300);
    chk(nwk - b, 1);
    chk(nrs - k, 0);
    rdc(STATUS_ADDR, 8'h00);
    chk(o_main_osc_en, 1'b1);
    chk(o_io_hold, 1'b0);
    // starve the watchdog in run mode
    kick <= 1'b0;
    waitev(nrs, 300);
    chk(nrs - k, 1);
    kick <= 1'b1;
    rdc(OPTION_ADDR, OPTION_RST);
    for (int g = 0; g < 2; g++) begin
      wr(IRQCTL_ADDR, {g[0], 7'h10});
      dosleep();
      b = nvc;
      k = nwk;
      i_ext_irq <= 1'b1;
      waitev(nwk, 50);
      chk(nwk - k, 1);
      repeat (20) @(posedge i_clk);
      chk(nvc - b, g);
      rdc(IRQCTL_ADDR, 8'h12);
      i_ext_irq <= 1'b0;
    end
    // flag still pending, so sleep is a no-op
    b = nwk;
    dosleep();
    #1 chk(o_sleeping, 1'b0);
    @(posedge i_clk);
    m = N_WAKE'(1) << $urandom_range(N_WAKE - 1);
    wr(IRQCTL_ADDR, 8'h40);
    wr(PIE_LO_ADDR, m[7:0]);
    wr(PIE_HI_ADDR, {7'h00, m[8]});
    dosleep();
    i_clocked_irq <= 1'b1;
    i_periph_flag <= ~m;
    repeat (20) @(posedge i_clk);
    chk(nwk - b, 0);
    i_clocked_irq <= 1'b0;
    i_periph_flag <= m;
    waitev(nwk, 50);
    chk(nwk - b, 1);
    i_periph_flag <= '0;
    @(posedge i_clk);
    dosleep();
    b = nrs;
    k = nwk;
    i_master_clear_pin_n <= 1'b0;
    waitev(nrs, 20);
    chk(nrs - b, 1);
    chk(nwk - k, 0);
    i_master_clear_pin_n <= 1'b1;
    // fuse cleared: no watchdog reset even when starved
    i_rst_n <= 1'b0;
    i_config_word <= 8'hFB;
    kick <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    wr(OPTION_ADDR, 8'h48);
    b = nrs;
    repeat (200) @(posedge i_clk);
    chk(nrs - b, 0);
    summarize();
  end
endmodule
